// ===== inc/branch_multiply_pkg.sv
package branch_multiply_pkg;

  // operand and address widths
  localparam int DATA_W = 8;
  localparam int PC_W   = 16;
  localparam int PROD_W = 16;
  localparam int OFS_W  = 7;
  localparam int CNT_W  = 2;

  // flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // cycle counts per instruction class
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // program counter steps
  localparam logic [PC_W-1:0] PC_STEP_NEXT  = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_ONE   = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_TWO   = 16'h0003;

  // overflow boundaries of increment and decrement results
  localparam logic [DATA_W-1:0] INC_OVF_VAL = 8'h80;
  localparam logic [DATA_W-1:0] DEC_OVF_VAL = 8'h7f;
  localparam logic [DATA_W-1:0] ONE_VAL     = 8'h01;

  // reset values
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 16'h0000;

  typedef enum logic [5:0] {
    increment_op, decrement_op, test_zero_minus_op,
    multiply_unsigned_op, multiply_signed_op, multiply_mixed_op,
    frac_multiply_unsigned_op, frac_multiply_signed_op,
    frac_multiply_mixed_op, indirect_jump_op, indirect_call_op,
    compare_skip_equal_op, compare_regs_op, compare_with_carry_op,
    compare_immediate_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op, branch_flag_set_op,
    branch_flag_clear_op, branch_equal_op, branch_not_equal_op,
    branch_carry_set_op, branch_carry_clear_op, branch_same_higher_op,
    branch_lower_op, branch_minus_op, branch_plus_op,
    branch_ge_signed_op, branch_lt_signed_op, branch_halfcarry_set_op,
    branch_halfcarry_clear_op, branch_tbit_set_op, branch_tbit_clear_op,
    branch_overflow_set_op, branch_overflow_clear_op
  } exec_op_t;

endpackage : branch_multiply_pkg

// ===== hdl/mul_unit.sv
`timescale 1ns/1ps
`default_nettype none

module mul_unit (
  // clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    rst,
  // operation
  input  wire logic                                    start,
  input  wire logic                                    signed_a,
  input  wire logic                                    signed_b,
  input  wire logic                                    frac,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0]  a_val,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0]  b_val,
  // result
  output var  logic [branch_multiply_pkg::PROD_W-1:0]  prod_q,
  output var  logic                                    carry_q,
  output var  logic                                    zero_q
);

  logic signed [8:0]  a_ext;
  logic signed [8:0]  b_ext;
  logic signed [17:0] full;
  logic [15:0]        raw;
  logic [15:0]        res;

  // extend each operand by its own signedness, then one signed product
  always_comb begin
    a_ext = $signed({signed_a & a_val[7], a_val});
    b_ext = $signed({signed_b & b_val[7], b_val});
    full  = a_ext * b_ext;
    raw   = full[15:0];
    res   = frac ? {raw[14:0], 1'b0} : raw;
  end

  // carry is the top bit before the fractional shift
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prod_q  <= 16'h0000;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end else if (start) begin
      prod_q  <= res;
      carry_q <= raw[15];
      zero_q  <= (res == 16'h0000);
    end
  end

endmodule : mul_unit

`default_nettype wire

// ===== hdl/branch_multiply_exec.sv
// Overview of operation
// RL1: increment/decrement one cycle, update Z N V
// RL2: test ANDs register with itself, keeps it
// RL3: multiplies write R1:R0, flags Z C, two cycles
// RL4: fractional multiplies shift product left one bit
// RL5: indirect jump loads PC from Z, two cycles
// RL6: indirect call loads PC from Z, three cycles
// RL7: compare-skip-equal skips next instruction, no flags
// RL8: compares subtract, update Z N V C H
// RL9: register bit skips test bit, skip next
// RL10: I/O bit skips test bit, skip next
// RL11: generic flag branches jump PC+k+1 when matched
// RL12: carry branches taken on carry 0 or 1
// RL13: signed ge branch taken when N xor V 0
// RL14: signed lt branch taken when N xor V 1
// RL15: half-carry branches follow H flag
// RL16: T-bit branches follow T flag
// RL17: overflow branches follow V flag
// RL18: minus/plus branches follow N flag
// RL19: equal/not-equal follow Z; branches keep flags
// RL20: indirect call pushes return address first
`timescale 1ns/1ps
`default_nettype none

module branch_multiply_exec (
  // clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   rst,
  // instruction issue
  input  wire logic                                   op_valid,
  input  wire branch_multiply_pkg::exec_op_t          op_sel,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0] rd_val,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0] rr_val,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0] imm_val,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0] io_val,
  input  wire logic [2:0]                             bit_sel,
  input  wire logic [branch_multiply_pkg::OFS_W-1:0]  offset,
  input  wire logic                                   next_two_word,
  // core state
  input  wire logic [branch_multiply_pkg::PC_W-1:0]   pc_in,
  input  wire logic [branch_multiply_pkg::PC_W-1:0]   z_ptr,
  input  wire logic [branch_multiply_pkg::DATA_W-1:0] flag_register,
  // status
  output var  logic                                   busy_q,
  output var  logic                                   done_q,
  // register file results
  output var  logic                                   rd_we_q,
  output var  logic [branch_multiply_pkg::DATA_W-1:0] rd_wdata_q,
  output var  logic                                   prod_we_q,
  output var  logic [branch_multiply_pkg::PROD_W-1:0] prod_q,
  // flag results
  output var  logic                                   flags_we_q,
  output var  logic [branch_multiply_pkg::DATA_W-1:0] flags_q,
  // program flow results
  output var  logic                                   pc_we_q,
  output var  logic [branch_multiply_pkg::PC_W-1:0]   pc_q,
  output var  logic                                   push_we_q,
  output var  logic [branch_multiply_pkg::PC_W-1:0]   push_data_q
);

  typedef enum logic {st_idle, st_busy} exec_state_t;

  exec_state_t state_q;
  logic [1:0]  cnt_q;
  logic        take;
  logic        fin;
  logic        pend_rd_q, pend_flags_q, pend_pc_q, pend_push_q, pend_mul_q;
  logic        d_rd_we, d_flags_we, d_pc_we, d_push, d_mul;
  logic [1:0]  d_cyc;
  logic [7:0]  d_res;
  logic [7:0]  d_flags;
  logic [15:0] d_pc;
  logic        d_cond;
  logic        m_sa, m_sb, m_frac;
  logic [15:0] mul_prod;
  logic        mul_carry, mul_zero;

  // sign-extended offset added to a program counter
  function automatic logic [15:0] pc_add(input logic [15:0] base,
                                         input logic [15:0] step);
    pc_add = base + step;
  endfunction : pc_add

  // flag set of an 8-bit subtraction a - b - cin
  function automatic logic [7:0] sub_flags(input logic [7:0] fin_in,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin,
                                           input logic       keep_z);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = fin_in;
    f[branch_multiply_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3])
                                   | (r[3] & ~a[3]);
    f[branch_multiply_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7])
                                   | (r[7] & ~a[7]);
    f[branch_multiply_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7])
                                   | (~a[7] & b[7] & r[7]);
    f[branch_multiply_pkg::FLAG_N] = r[7];
    // with-carry form only keeps Z set, so multi-byte compares chain
    f[branch_multiply_pkg::FLAG_Z] = (r == 8'h00) &
      (~keep_z | fin_in[branch_multiply_pkg::FLAG_Z]);
    sub_flags = f;
  endfunction : sub_flags

  assign take = op_valid && (state_q == st_idle);
  assign fin  = (state_q == st_busy) && (cnt_q == 2'h1);

  // decode of one accepted instruction into results and cycle count
  always_comb begin
    d_rd_we = 1'b0;
    d_flags_we = 1'b0;
    d_pc_we = 1'b0;
    d_push = 1'b0;
    d_mul = 1'b0;
    d_cyc = branch_multiply_pkg::CYC_ONE;
    d_res = rd_val;
    d_flags = flag_register;
    d_pc = pc_add(pc_in, {{9{offset[6]}}, offset} +
                  branch_multiply_pkg::PC_STEP_NEXT);
    d_cond = 1'b0;
    m_sa = 1'b0;
    m_sb = 1'b0;
    m_frac = 1'b0;
    unique case (op_sel)
      branch_multiply_pkg::increment_op,
      branch_multiply_pkg::decrement_op,
      branch_multiply_pkg::test_zero_minus_op: begin
        if (op_sel == branch_multiply_pkg::increment_op) begin
          d_res = rd_val + branch_multiply_pkg::ONE_VAL; // RL1
        end else if (op_sel == branch_multiply_pkg::decrement_op) begin
          d_res = rd_val - branch_multiply_pkg::ONE_VAL; // RL1
        end
        d_rd_we = (op_sel != branch_multiply_pkg::test_zero_minus_op); // RL2
        d_flags_we = 1'b1;
        // test keeps d_res equal to rd_val, so this is rd_val & rd_val
        d_flags[branch_multiply_pkg::FLAG_Z] = (d_res == 8'h00); // RL1
        d_flags[branch_multiply_pkg::FLAG_N] = d_res[7];
        unique case (op_sel)
          branch_multiply_pkg::increment_op:
            d_flags[branch_multiply_pkg::FLAG_V] =
              (d_res == branch_multiply_pkg::INC_OVF_VAL); // RL1
          branch_multiply_pkg::decrement_op:
            d_flags[branch_multiply_pkg::FLAG_V] =
              (d_res == branch_multiply_pkg::DEC_OVF_VAL); // RL1
          default: d_flags[branch_multiply_pkg::FLAG_V] = 1'b0; // RL2
        endcase
      end
      branch_multiply_pkg::multiply_unsigned_op,
      branch_multiply_pkg::multiply_signed_op,
      branch_multiply_pkg::multiply_mixed_op,
      branch_multiply_pkg::frac_multiply_unsigned_op,
      branch_multiply_pkg::frac_multiply_signed_op,
      branch_multiply_pkg::frac_multiply_mixed_op: begin
        d_mul = 1'b1; // RL3
        d_flags_we = 1'b1;
        d_cyc = branch_multiply_pkg::CYC_TWO; // RL3
        m_sa = (op_sel == branch_multiply_pkg::multiply_signed_op) ||
               (op_sel == branch_multiply_pkg::multiply_mixed_op) ||
               (op_sel == branch_multiply_pkg::frac_multiply_signed_op) ||
               (op_sel == branch_multiply_pkg::frac_multiply_mixed_op);
        m_sb = (op_sel == branch_multiply_pkg::multiply_signed_op) ||
               (op_sel == branch_multiply_pkg::frac_multiply_signed_op);
        m_frac = (op_sel == branch_multiply_pkg::frac_multiply_unsigned_op)
            || (op_sel == branch_multiply_pkg::frac_multiply_signed_op)
            || (op_sel == branch_multiply_pkg::frac_multiply_mixed_op); // RL4
      end
      branch_multiply_pkg::indirect_jump_op: begin
        d_pc_we = 1'b1;
        d_pc = z_ptr; // RL5
        d_cyc = branch_multiply_pkg::CYC_TWO; // RL5
      end
      branch_multiply_pkg::indirect_call_op: begin
        d_pc_we = 1'b1;
        d_push = 1'b1; // RL20
        d_pc = z_ptr; // RL6
        d_cyc = branch_multiply_pkg::CYC_THREE; // RL6
      end
      branch_multiply_pkg::compare_regs_op,
      branch_multiply_pkg::compare_with_carry_op,
      branch_multiply_pkg::compare_immediate_op: begin
        d_flags_we = 1'b1; // RL8
        d_flags = sub_flags(flag_register, rd_val,
          (op_sel == branch_multiply_pkg::compare_immediate_op) ?
            imm_val : rr_val,
          (op_sel == branch_multiply_pkg::compare_with_carry_op) &
            flag_register[branch_multiply_pkg::FLAG_C],
          op_sel == branch_multiply_pkg::compare_with_carry_op); // RL8
      end
      branch_multiply_pkg::compare_skip_equal_op,
      branch_multiply_pkg::skip_reg_bit_clear_op,
      branch_multiply_pkg::skip_reg_bit_set_op,
      branch_multiply_pkg::skip_io_bit_clear_op,
      branch_multiply_pkg::skip_io_bit_set_op: begin
        unique case (op_sel)
          branch_multiply_pkg::compare_skip_equal_op:
            d_cond = (rd_val == rr_val); // RL7
          branch_multiply_pkg::skip_reg_bit_clear_op:
            d_cond = ~rr_val[bit_sel]; // RL9
          branch_multiply_pkg::skip_reg_bit_set_op:
            d_cond = rr_val[bit_sel]; // RL9
          branch_multiply_pkg::skip_io_bit_clear_op:
            d_cond = ~io_val[bit_sel]; // RL10
          default: d_cond = io_val[bit_sel]; // RL10
        endcase
        // skip length follows the size of the instruction jumped over
        d_pc_we = d_cond;
        d_pc = pc_add(pc_in, next_two_word ?
          branch_multiply_pkg::PC_SKIP_TWO : branch_multiply_pkg::PC_SKIP_ONE);
        d_cyc = !d_cond ? branch_multiply_pkg::CYC_ONE :
                next_two_word ? branch_multiply_pkg::CYC_THREE :
                branch_multiply_pkg::CYC_TWO; // RL7
      end
      default: begin
        // every remaining code is a flag branch; flags untouched
        unique case (op_sel)
          branch_multiply_pkg::branch_flag_set_op:
            d_cond = flag_register[bit_sel]; // RL11
          branch_multiply_pkg::branch_flag_clear_op:
            d_cond = ~flag_register[bit_sel]; // RL11
          branch_multiply_pkg::branch_equal_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_Z]; // RL19
          branch_multiply_pkg::branch_not_equal_op:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_Z]; // RL19
          branch_multiply_pkg::branch_carry_set_op,
          branch_multiply_pkg::branch_lower_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_C]; // RL12
          branch_multiply_pkg::branch_carry_clear_op,
          branch_multiply_pkg::branch_same_higher_op:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_C]; // RL12
          branch_multiply_pkg::branch_minus_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_N]; // RL18
          branch_multiply_pkg::branch_plus_op:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_N]; // RL18
          branch_multiply_pkg::branch_ge_signed_op:
            d_cond = ~(flag_register[branch_multiply_pkg::FLAG_N] ^
                       flag_register[branch_multiply_pkg::FLAG_V]); // RL13
          branch_multiply_pkg::branch_lt_signed_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_N] ^
                     flag_register[branch_multiply_pkg::FLAG_V]; // RL14
          branch_multiply_pkg::branch_halfcarry_set_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_H]; // RL15
          branch_multiply_pkg::branch_halfcarry_clear_op:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_H]; // RL15
          branch_multiply_pkg::branch_tbit_set_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_T]; // RL16
          branch_multiply_pkg::branch_tbit_clear_op:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_T]; // RL16
          branch_multiply_pkg::branch_overflow_set_op:
            d_cond = flag_register[branch_multiply_pkg::FLAG_V]; // RL17
          default:
            d_cond = ~flag_register[branch_multiply_pkg::FLAG_V]; // RL17
        endcase
        d_pc_we = d_cond; // RL11
        d_cyc = d_cond ? branch_multiply_pkg::CYC_TWO :
                         branch_multiply_pkg::CYC_ONE; // RL12
      end
    endcase
  end

  // product is registered on acceptance and copied out one cycle later
  mul_unit u_mul (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (take && d_mul),
    .signed_a (m_sa),
    .signed_b (m_sb),
    .frac     (m_frac),
    .a_val    (rd_val),
    .b_val    (rr_val),
    .prod_q   (mul_prod),
    .carry_q  (mul_carry),
    .zero_q   (mul_zero)
  );

  // sequencer: a one-cycle op never enters the busy state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
      cnt_q   <= 2'h0;
      busy_q  <= 1'b0;
    end else if (take && (d_cyc != branch_multiply_pkg::CYC_ONE)) begin
      state_q <= st_busy;
      cnt_q   <= d_cyc - 2'h1;
      busy_q  <= 1'b1;
    end else if (state_q == st_busy) begin
      cnt_q <= cnt_q - 2'h1;
      if (fin) begin
        state_q <= st_idle;
        busy_q  <= 1'b0;
      end
    end
  end

  // remember which results are owed at the end of a long op
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_rd_q    <= 1'b0;
      pend_flags_q <= 1'b0;
      pend_pc_q    <= 1'b0;
      pend_push_q  <= 1'b0;
      pend_mul_q   <= 1'b0;
    end else if (take) begin
      pend_rd_q    <= d_rd_we;
      pend_flags_q <= d_flags_we;
      pend_pc_q    <= d_pc_we;
      pend_push_q  <= d_push;
      pend_mul_q   <= d_mul;
    end
  end

  // strobes: at acceptance for one-cycle ops, at the last cycle otherwise, except the push one cycle before the last
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_q     <= 1'b0;
      rd_we_q    <= 1'b0;
      flags_we_q <= 1'b0;
      pc_we_q    <= 1'b0;
      prod_we_q  <= 1'b0;
      push_we_q  <= 1'b0;
    end else begin
      done_q     <= (take && d_cyc == branch_multiply_pkg::CYC_ONE) || fin;
      rd_we_q    <= (take && d_cyc == branch_multiply_pkg::CYC_ONE &&
                     d_rd_we) || (fin && pend_rd_q);
      flags_we_q <= (take && d_cyc == branch_multiply_pkg::CYC_ONE &&
                     d_flags_we) || (fin && pend_flags_q);
      pc_we_q    <= (take && d_cyc == branch_multiply_pkg::CYC_ONE &&
                     d_pc_we) || (fin && pend_pc_q);
      prod_we_q  <= fin && pend_mul_q; // RL3
      // return address goes out the cycle before the new PC lands
      push_we_q  <= (state_q == st_busy) && (cnt_q == 2'h2) &&
                    pend_push_q; // RL20
    end
  end

  // result data, held until the next instruction replaces it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_wdata_q  <= 8'h00;
      flags_q     <= branch_multiply_pkg::FLAGS_RST;
      pc_q        <= branch_multiply_pkg::PC_RST;
      push_data_q <= branch_multiply_pkg::PC_RST;
      prod_q      <= 16'h0000;
    end else if (take) begin
      rd_wdata_q  <= d_res;
      flags_q     <= d_flags;
      pc_q        <= d_pc;
      push_data_q <= pc_add(pc_in, branch_multiply_pkg::PC_STEP_NEXT);
    end else if (fin && pend_mul_q) begin
      prod_q <= mul_prod; // RL3
      flags_q[branch_multiply_pkg::FLAG_Z] <= mul_zero; // RL3
      flags_q[branch_multiply_pkg::FLAG_C] <= mul_carry; // RL3
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  inc_value_a: assert property (take && op_sel ==  // RL1
    branch_multiply_pkg::increment_op |=> done_q && rd_we_q &&
    rd_wdata_q == 8'($past(rd_val) + 8'h01))
    else $error("increment result wrong");
  tst_keep_a: assert property (take && op_sel ==  // RL2
    branch_multiply_pkg::test_zero_minus_op |=> done_q && !rd_we_q &&
    flags_we_q && !flags_q[branch_multiply_pkg::FLAG_V])
    else $error("test altered register or overflow");
  mul_two_a: assert property (take && op_sel ==  // RL3
    branch_multiply_pkg::multiply_unsigned_op |=> !done_q ##1
    (done_q && prod_we_q && flags_we_q))
    else $error("multiply not two cycles");
  frac_shift_a: assert property (take && op_sel ==  // RL4
    branch_multiply_pkg::frac_multiply_unsigned_op |=> ##1 !prod_q[0])
    else $error("fractional product not shifted");
  indirect_jump_op_pc_a: assert property (take && op_sel ==  // RL5
    branch_multiply_pkg::indirect_jump_op |=> !pc_we_q ##1
    (pc_we_q && !flags_we_q && pc_q == $past(z_ptr, 2)))
    else $error("indirect jump target or timing wrong");
  indirect_call_op_push_a: assert property (take && op_sel ==  // RL6
    branch_multiply_pkg::indirect_call_op |=> !done_q ##1
    (push_we_q && !pc_we_q) ##1 (pc_we_q && done_q))
    else $error("indirect call sequence wrong");
  cmp_carry_a: assert property (take && op_sel ==  // RL8
    branch_multiply_pkg::compare_regs_op |=> flags_we_q &&
    flags_q[branch_multiply_pkg::FLAG_C] == ($past(rd_val) < $past(rr_val)))
    else $error("compare carry wrong");
  skip_three_a: assert property (take && op_sel ==  // RL7
    branch_multiply_pkg::compare_skip_equal_op && rd_val == rr_val &&
    next_two_word |=> !done_q [*2] ##1 (done_q && pc_we_q))
    else $error("skip over two-word not three cycles");
  brc_idle_a: assert property (take && op_sel ==  // RL12
    branch_multiply_pkg::branch_carry_set_op &&
    !flag_register[branch_multiply_pkg::FLAG_C] |=> done_q && !pc_we_q)
    else $error("untaken carry branch moved pc");
  branch_lt_signed_op_take_a: assert property (take && op_sel ==  // RL14
    branch_multiply_pkg::branch_lt_signed_op &&
    (flag_register[branch_multiply_pkg::FLAG_N] ^
     flag_register[branch_multiply_pkg::FLAG_V]) |=> !done_q ##1 pc_we_q)
    else $error("signed lt branch not taken in two cycles");
  pc_noflag_a: assert property (pc_we_q |-> !flags_we_q) // RL19
    else $error("flow change wrote flags");

  mul_done_c: cover property (prod_we_q &&
    flags_q[branch_multiply_pkg::FLAG_C]);
  call_done_c: cover property (push_we_q ##1 pc_we_q);
  branch_taken_c: cover property (take ##1 !done_q ##1 pc_we_q);

endmodule : branch_multiply_exec

`default_nettype wire

// ===== tb/branch_multiply_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module branch_multiply_exec_tb_top;
  logic        core_clk = 1'b0;
  logic        rst, op_valid, next_two_word, busy_q, done_q, rd_we_q;
  logic        prod_we_q, flags_we_q, pc_we_q, push_we_q;
  logic [2:0]  bit_sel;
  logic [7:0]  rd_val, rr_val, flag_register, rd_wdata_q, flags_q, op;
  logic [15:0] prod_q, pc_q, push_data_q, push_seen;
  logic [31:0] obs;
  int          miscompares, tests_run, cycles, ncyc;
  branch_multiply_pkg::exec_op_t op_sel;
  // row: op index, rd, rr, flags, two-word/bit, cycles, expected result
  logic [71:0] tab [41] = '{
    72'h007f000001010c0080, 72'h01800000010108007f, 72'h010100040101020000,
    72'h028000080100040000, 72'h0c0505000100020000, 72'h0d0000030100250000,
    72'h0e0001000100250000, 72'h03ffff00020101fe01, 72'h04ff0200020101fffe,
    72'h05ff0200020101fffe, 72'h068080000201008000, 72'h078080000201008000,
    72'h08ff0200020101fffc, 72'h030037000201020000, 72'h0b5555558300010103,
    72'h0f0000000200010102, 72'h100000000100000000, 72'h111010104100000000,
    72'h121010104200010102, 72'h090000000200011234, 72'h1380808072000100fe,
    72'h140808083100000000, 72'h1502020202000100fe, 72'h160202020100000000,
    72'h1701010102000100fe, 72'h1800000002000100fe, 72'h190101010100000000,
    72'h1a01010102000100fe, 72'h1b04040402000100fe, 72'h1c0404040100000000,
    72'h1d0c0c0c02000100fe, 72'h1e04040402000100fe, 72'h1f0000000100000000,
    72'h2000000002000100fe, 72'h2140404002000100fe, 72'h224040400100000000,
    72'h2308080802000100fe, 72'h2400000002000100fe, 72'h100101018300010103,
    72'h0a0000000300011234, 72'h170000000100000000};
  // offset -3 from 0x0100 puts every taken branch at 0x00fe
  branch_multiply_exec u_branch_multiply_exec (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_sel(op_sel),
    .rd_val(rd_val), .rr_val(rr_val), .imm_val(rr_val), .io_val(rr_val),
    .bit_sel(bit_sel), .offset(7'h7d), .next_two_word(next_two_word),
    .pc_in(16'h0100), .z_ptr(16'h1234), .flag_register(flag_register),
    .busy_q(busy_q), .done_q(done_q), .rd_we_q(rd_we_q),
    .rd_wdata_q(rd_wdata_q), .prod_we_q(prod_we_q), .prod_q(prod_q),
    .flags_we_q(flags_we_q), .flags_q(flags_q), .pc_we_q(pc_we_q),
    .pc_q(pc_q), .push_we_q(push_we_q), .push_data_q(push_data_q));
  // 100 mhz core clock
  initial forever #5 core_clk = ~core_clk;
  // hang guard: the whole table needs about 110 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      close_out();
    end
  end
  // case equality so an unknown never counts as a match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // issue one instruction, count cycles to done, catch the stack push
  task automatic run(input logic [71:0] s);
    @(posedge core_clk) #1;
    op_sel = branch_multiply_pkg::exec_op_t'(s[69:64]);
    {rd_val, rr_val, flag_register} = s[63:40];
    {next_two_word, bit_sel} = s[39:36];
    op_valid = 1'b1;
    @(posedge core_clk) #1;
    op_valid = 1'b0;
    ncyc = 1;
    while (done_q !== 1'b1 && ncyc < 8) begin
      if (push_we_q === 1'b1)
        push_seen = push_data_q;
      @(posedge core_clk) #1;
      ncyc++;
    end
  endtask : run
  // reset, then every row; result view depends on the instruction class
  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_sel = branch_multiply_pkg::increment_op;
    {rd_val, rr_val, flag_register, next_two_word, bit_sel} = '0;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(32'({busy_q, done_q, rd_we_q, pc_we_q, flags_we_q, push_we_q}), 32'h0);
    $display("reset test done");
    foreach (tab[i]) begin
      run(tab[i]);
      op = tab[i][71:64];
      chk(32'(ncyc), 32'(tab[i][35:32]));
      if (op inside {[8'h03:8'h08]})
        obs = {7'h0, prod_we_q, flags_q, prod_q};
      else if (op < 8'h03 || op inside {[8'h0c:8'h0e]})
        obs = {7'h0, rd_we_q, flags_q, 8'h0, rd_we_q ? rd_wdata_q : 8'h0};
      else
        obs = {7'h0, flags_we_q, 7'h0, pc_we_q, pc_we_q ? pc_q : 16'h0};
      chk(obs, tab[i][31:0]);
      $display("row %0d done", i);
    end
    chk(32'(push_seen), 32'h00000101);
    // held request: refused while the multiply runs, taken once idle,
    // then a second one-cycle op issues on the very next edge
    @(posedge core_clk) #1;
    op_sel = branch_multiply_pkg::multiply_unsigned_op;
    {rd_val, rr_val, flag_register} = 24'h030500;
    op_valid = 1'b1;
    @(posedge core_clk) #1;
    chk(32'({busy_q, done_q}), 32'h2);
    op_sel = branch_multiply_pkg::increment_op;
    @(posedge core_clk) #1;
    chk(32'({rd_we_q, prod_we_q, busy_q, prod_q}), 32'h0002000f);
    @(posedge core_clk) #1;
    chk(32'({done_q, rd_we_q, rd_wdata_q}), 32'h304);
    rd_val = 8'h7f;
    @(posedge core_clk) #1;
    chk(32'({done_q, rd_we_q, rd_wdata_q}), 32'h380);
    $display("held request test done");
    // reset in mid call: nothing owed may come out afterwards
    op_sel = branch_multiply_pkg::indirect_call_op;
    @(posedge core_clk) #1;
    op_valid = 1'b0;
    rst = 1'b1;
    @(posedge core_clk) #1;
    rst = 1'b0;
    repeat (3) begin
      @(posedge core_clk) #1;
      chk(32'({busy_q, done_q, pc_we_q, push_we_q}), 32'h0);
    end
    $display("mid-run reset test done");
    close_out();
  end
endmodule : branch_multiply_exec_tb_top
`default_nettype wire
